// [rtl/spi_pkg.sv]
// shared constants, configuration and state types of the four-select serial master
package spi_pkg;

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int NUM_CS = 4;         // chip select outputs
  localparam int CS_W = 2;           // index of a chip select
  localparam int CHAR_W = 32;        // longest character in bits
  localparam int LEN_W = 5;          // character length minus one
  localparam int FRAME_W = 12;       // frame length minus one (1..4096)
  localparam int DIV_W = 8;          // serial clock half-period divider
  localparam int DLY_W = 2;          // select-to-data delay, 0..3 clocks
  localparam int LEAD_W = 3;         // half-period count of that delay
  localparam int FIFO_DEPTH = 16;    // words held ahead of the shifter

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
  localparam logic [LEN_W-1:0] LEN_RST = 5'h07;
  localparam logic [FRAME_W-1:0] FRAME_RST = 12'h000;
  localparam logic [LEN_W-1:0] LEN_TOP = 5'h1f; // CHAR_W - 1

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  // per-frame settings, caught when a frame starts
  typedef struct packed {
    logic [DIV_W-1:0] half_div;   // half period = half_div + 1 sys clocks
    logic [LEN_W-1:0] len_m1;     // bits per character minus one
    logic [FRAME_W-1:0] frame_m1; // characters per frame minus one
    logic [CS_W-1:0] cs_index;    // which slave is addressed
    logic [DLY_W-1:0] cs_delay;   // serial clocks from select to data
    logic loopback;               // feed transmit back to receive
    logic irq_enable;             // pulse an interrupt per character
  } spi_cfg_t;

  // one received character
  typedef struct packed {
    logic [CHAR_W-1:0] data;
    logic valid;
  } rx_word_t;

  // engine sequencing
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_LOAD,
    ST_SHIFT,
    ST_TRAIL
  } eng_state_t;

endpackage : spi_pkg

// [rtl/char_fifo.sv]
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module char_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [WIDTH-1:0] wr_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [WIDTH-1:0] rd_data
);
  import spi_pkg::*;

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // storage, indexed by pointer
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;               // one bit wider to tell full
  } fifo_t;

  fifo_t st_r;
  fifo_t st_nxt;
  logic push;
  logic pop;

  // handshakes straight from the count
  assign wr_ready = (st_r.count != (AW+1)'(DEPTH));
  assign rd_valid = (st_r.count != '0);
  assign rd_data = st_r.mem[st_r.rd_ptr];
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // pointers wrap at DEPTH, which need not be a power of two
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr_ptr] = wr_data;
      st_nxt.wr_ptr = (st_r.wr_ptr == AW'(DEPTH-1)) ? '0 : st_r.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_nxt.rd_ptr = (st_r.rd_ptr == AW'(DEPTH-1)) ? '0 : st_r.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_nxt.count = st_r.count + 1'b1;
    end else if (pop && !push) begin
      st_nxt.count = st_r.count - 1'b1;
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : char_fifo

// [rtl/spi_master_four_select.sv]
// master-only serial port with four chip selects and a transmit fifo
// Operation
// R1: master only; drives clock and selects itself
// R2: shifts data out and in at bit rate
// R3: character length programmable from 1 to 32
// R4: four separate chip select outputs
// R5: frame holds 1 to 4096 characters exactly
// R6: optional interrupt pulse per finished character
// R7: select-to-first-data delay of 0..3 clocks
// R8: serial clock from programmable system clock divider
// R9: internal loopback feeds transmit into receiver
// R10: no dma request path; ports only
// R11: per-select polarity and phase pick mode 0..3
// R12: per-select chip select active level configurable
// R13: select held for whole frame, released after
// R14: slave drives on opposite edge, ignores unselected
`timescale 1ns/100ps
module spi_master_four_select #(
  parameter int FIFO_WORDS = spi_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire spi_pkg::spi_cfg_t cfg,
  input wire logic [spi_pkg::NUM_CS-1:0] clock_polarity_sel,
  input wire logic [spi_pkg::NUM_CS-1:0] clock_phase_sel,
  input wire logic [spi_pkg::NUM_CS-1:0] cs_active_high,
  input wire logic start,
  output logic busy,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic [spi_pkg::CHAR_W-1:0] tx_data,
  output spi_pkg::rx_word_t rx_word,
  output logic char_irq,
  output logic spi_clk_out,
  output logic spi_tx_out,
  input wire logic spi_rx_in,
  output logic [spi_pkg::NUM_CS-1:0] slave_select_out
);
  import spi_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    eng_state_t st;
    spi_cfg_t cfg;                    // settings of the running frame
    logic cpol;                       // idle clock level of the frame
    logic cpha;                       // 1: drive on leading edge
    logic [DIV_W-1:0] div_cnt;        // sys clocks to next clock edge
    logic [LEAD_W-1:0] lead_cnt;      // half periods left before data
    logic lead_edge;                  // next clock edge is the leading one
    logic [LEN_W-1:0] bit_cnt;        // bits finished in this character
    logic [FRAME_W-1:0] char_cnt;     // characters finished in frame
    logic [CHAR_W-1:0] tx_sh;         // left-aligned bits still to send
    logic [CHAR_W-1:0] rx_sh;         // right-aligned bits received
    logic tx_out;                     // transmit pin
    logic sclk;                       // serial clock pin
    logic [NUM_CS-1:0] cs_out;        // chip select pins
    logic rx_meta;                    // receive pin, first stage
    logic rx_sync;                    // receive pin, second stage
    rx_word_t rx;                     // last finished character
    logic irq;                        // one-cycle character pulse
  } eng_t;

  eng_t s_r;
  eng_t s_nxt;
  logic fifo_valid;
  logic fifo_pop;
  logic [CHAR_W-1:0] fifo_data;

  // ----------------------------------------------------------------
  // transmit fifo
  // ----------------------------------------------------------------
  // the engine stalls in load with the clock parked when it runs dry,
  // so software may keep feeding a long frame through tx_ready
  char_fifo #(
    .WIDTH(CHAR_W),
    .DEPTH(FIFO_WORDS)
  ) u_tx_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .wr_valid(tx_valid),
    .wr_ready(tx_ready),
    .wr_data(tx_data),
    .rd_valid(fifo_valid),
    .rd_ready(fifo_pop),
    .rd_data(fifo_data)
  );

  assign fifo_pop = (s_r.st == ST_LOAD) && fifo_valid;

  // ----------------------------------------------------------------
  // outputs, all from the state register
  // ----------------------------------------------------------------
  // data moves only through these ports; there is no dma request R10
  assign busy = (s_r.st != ST_IDLE);
  assign rx_word = s_r.rx;
  assign char_irq = s_r.irq;
  assign spi_clk_out = s_r.sclk; // R1
  assign spi_tx_out = s_r.tx_out;
  assign slave_select_out = s_r.cs_out; // R4

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic tick;
    logic in_bit;
    logic [CHAR_W-1:0] rx_new;
    logic [LEN_W-1:0] align;
    logic act;
    tick = 1'b0;
    in_bit = 1'b0;
    rx_new = '0;
    align = '0;
    act = 1'b0;
    s_nxt = s_r;
    s_nxt.rx.valid = 1'b0;
    s_nxt.irq = 1'b0;
    // receive pin crosses in through two flops
    s_nxt.rx_meta = spi_rx_in;
    s_nxt.rx_sync = s_r.rx_meta;
    // loopback takes the pin out of the path entirely
    in_bit = s_r.cfg.loopback ? s_r.tx_out : s_r.rx_sync; // R9
    // half-period divider runs in every timed state
    if (s_r.st == ST_LEAD || s_r.st == ST_SHIFT || s_r.st == ST_TRAIL) begin
      if (s_r.div_cnt == '0) begin
        tick = 1'b1;
        s_nxt.div_cnt = s_r.cfg.half_div; // R8
      end else begin
        s_nxt.div_cnt = s_r.div_cnt - 1'b1;
      end
    end
    unique case (s_r.st)
      ST_IDLE: begin
        // idle clock level follows the addressed slave's mode
        s_nxt.sclk = clock_polarity_sel[cfg.cs_index]; // R11
        if (start) begin
          s_nxt.st = ST_LEAD;
          s_nxt.cfg = cfg;
          s_nxt.cpol = clock_polarity_sel[cfg.cs_index]; // R11
          s_nxt.cpha = clock_phase_sel[cfg.cs_index]; // R11
          s_nxt.div_cnt = cfg.half_div;
          // 2*delay+1 half periods: delay whole clocks plus setup
          s_nxt.lead_cnt = {cfg.cs_delay, 1'b0}; // R7
          s_nxt.char_cnt = '0;
        end
      end
      ST_LEAD: begin
        if (tick) begin
          if (s_r.lead_cnt == '0) begin
            s_nxt.st = ST_LOAD;
          end else begin
            s_nxt.lead_cnt = s_r.lead_cnt - 1'b1; // R7
          end
        end
      end
      ST_LOAD: begin
        // wait here, clock idle and select held, until a word is there
        if (fifo_valid) begin
          align = LEN_TOP - s_r.cfg.len_m1;
          s_nxt.tx_sh = fifo_data << align; // R3
          s_nxt.rx_sh = '0;
          s_nxt.bit_cnt = '0;
          s_nxt.lead_edge = 1'b1;
          s_nxt.div_cnt = s_r.cfg.half_div;
          s_nxt.st = ST_SHIFT;
          if (!s_r.cpha) begin
            // phase 0 puts the first bit out half a period early
            s_nxt.tx_out = s_nxt.tx_sh[CHAR_W-1]; // R2
            s_nxt.tx_sh = s_nxt.tx_sh << 1;
          end
        end
      end
      ST_SHIFT: begin
        if (tick) begin
          s_nxt.sclk = ~s_r.sclk; // R8
          if (s_r.lead_edge) begin
            s_nxt.lead_edge = 1'b0;
            if (s_r.cpha) begin
              // phase 1 drives on the leading edge R11
              s_nxt.tx_out = s_r.tx_sh[CHAR_W-1]; // R2
              s_nxt.tx_sh = s_r.tx_sh << 1;
            end else begin
              s_nxt.rx_sh = {s_r.rx_sh[CHAR_W-2:0], in_bit}; // R2
            end
          end else begin
            s_nxt.lead_edge = 1'b1;
            s_nxt.bit_cnt = s_r.bit_cnt + 1'b1;
            rx_new = s_r.rx_sh;
            if (s_r.cpha) begin
              // slave changed its bit on the leading edge R14
              rx_new = {s_r.rx_sh[CHAR_W-2:0], in_bit}; // R2
            end else if (s_r.bit_cnt != s_r.cfg.len_m1) begin
              s_nxt.tx_out = s_r.tx_sh[CHAR_W-1];
              s_nxt.tx_sh = s_r.tx_sh << 1;
            end
            s_nxt.rx_sh = rx_new;
            if (s_r.bit_cnt == s_r.cfg.len_m1) begin
              // exactly len_m1+1 bits make a character R3
              s_nxt.rx.data = rx_new;
              s_nxt.rx.valid = 1'b1;
              s_nxt.irq = s_r.cfg.irq_enable; // R6
              if (s_r.char_cnt == s_r.cfg.frame_m1) begin
                s_nxt.st = ST_TRAIL; // R5
              end else begin
                s_nxt.char_cnt = s_r.char_cnt + 1'b1; // R5
                s_nxt.st = ST_LOAD; // R13
              end
            end
          end
        end
      end
      ST_TRAIL: begin
        // half a period of hold after the last edge, then release
        if (tick) begin
          s_nxt.st = ST_IDLE; // R13
        end
      end
    endcase
    // select pins: asserted for the whole frame, at each pin's level
    for (int i = 0; i < NUM_CS; i++) begin
      act = (s_nxt.st != ST_IDLE) && (s_nxt.cfg.cs_index == CS_W'(i)); // R13
      s_nxt.cs_out[i] = cs_active_high[i] ? act : ~act; // R12
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // selects reset to all-ones: inactive for the customary low level
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.cfg.half_div <= DIV_RST;
      s_r.cfg.len_m1 <= LEN_RST;
      s_r.cfg.frame_m1 <= FRAME_RST;
      s_r.cs_out <= '1;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : spi_master_four_select

// [testbench/spi_master_props.sv]
// concurrent checks on the ports of the four-select serial master
`timescale 1ns/100ps
module spi_master_props (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire spi_pkg::spi_cfg_t cfg,
  input wire logic [3:0] clock_polarity_sel,
  input wire logic [3:0] cs_active_high,
  input wire logic start,
  input wire logic busy,
  input wire spi_pkg::rx_word_t rx_word,
  input wire logic char_irq,
  input wire logic spi_clk_out,
  input wire logic [3:0] slave_select_out
);
  import spi_pkg::*;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one bit per select sitting at its active level
  wire [3:0] act = ~(slave_select_out ^ cs_active_high);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // accepted start, then busy
  sequence s_go;
    start && !busy ##1 busy;
  endsequence
  // two idle cycles in a row; outputs lag inputs by one register
  sequence s_idle;
    !busy ##1 !busy;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  chk_one_select: assert property (
    $stable(cs_active_high) |-> $countones(act) <= 1) else $error("two selects active");
  chk_frame_select: assert property (s_go |-> act[cfg.cs_index])
    else $error("frame began without its select");
  chk_select_held: assert property (
    busy && $past(busy) |-> $stable(slave_select_out)) else $error("select moved in frame");
  chk_idle_release: assert property (
    s_idle ##0 $stable(cs_active_high) |-> act == 4'h0) else $error("select active while idle");
  chk_idle_clock: assert property (
    s_idle ##0 ($stable(clock_polarity_sel) && $stable(cfg))
    |-> spi_clk_out == clock_polarity_sel[cfg.cs_index]) else $error("idle clock level wrong");
  chk_irq_valid: assert property (char_irq |-> rx_word.valid)
    else $error("interrupt without a character");
  chk_irq_off: assert property (busy && !cfg.irq_enable |-> !char_irq)
    else $error("interrupt while disabled");
  chk_valid_busy: assert property (rx_word.valid |-> busy ##1 !rx_word.valid)
    else $error("character outside frame or too long");
endmodule : spi_master_props

bind spi_master_four_select spi_master_props i_props (.sys_clk, .arst_n, .cfg,
  .clock_polarity_sel, .cs_active_high, .start, .busy, .rx_word, .char_irq,
  .spi_clk_out, .slave_select_out);

// [testbench/spi_slave_model.sv]
// behavioural serial slave that answers a fixed word per character
`timescale 1ns/100ps
module spi_slave_model (
  input wire logic sclk,
  input wire logic mosi,
  input wire logic [3:0] sel,
  input wire logic [3:0] act_high,
  input wire logic [1:0] idx,
  input wire logic pol,
  input wire logic pha,
  input wire logic [4:0] len_m1,
  input wire logic [31:0] reply,
  output logic miso,
  output logic [31:0] got_word
);
  logic [31:0] sh; // bits taken so far
  int cnt; // bits sampled in this character
  wire on = (sel[idx] == act_high[idx]);
  initial begin
    miso = 1'b0;
    got_word = '0;
  end
  // select edge: restart, and with phase 0 show the first bit at once
  always @(on) begin
    cnt = 0;
    sh = '0;
    if (on && !pha) miso = reply[len_m1];
    else if (!on) miso = ~miso; // released line flips to the opposite level
  end
  // clock ignored while unselected; sample on one edge, drive on the other
  always @(sclk) if (on) begin
    if ((sclk != pol) ^ pha) begin
      sh = {sh[30:0], mosi};
      cnt++;
      if (cnt == len_m1 + 1) begin
        got_word = sh;
        cnt = 0;
        sh = '0;
      end
    end else miso = reply[len_m1 - cnt];
  end
endmodule : spi_slave_model

// [testbench/spi_master_four_select_test.sv]
// self-checking bench of the four-select serial master against a slave model
`timescale 1ns/100ps
module spi_master_four_select_test;
  import spi_pkg::*;
  logic sys_clk = 1'b0, arst_n = 1'b0, start = 1'b0, tx_valid = 1'b0;
  spi_cfg_t cfg = '0;
  logic [3:0] pol = '0, pha = '0, hi = '0;
  logic [31:0] tx_data = '0, reply = '0, got;
  logic busy, tx_ready, char_irq, sclk, mosi, miso;
  logic [3:0] sel;
  rx_word_t rx_word;
  int errors = 0, checked = 0, seed = 13545, nv, ni;
  logic [31:0] exp_q[$], tx_q[$]; // model: expected receive and transmit words

  spi_master_four_select i_dut (.sys_clk, .arst_n, .cfg, .clock_polarity_sel(pol),
    .clock_phase_sel(pha), .cs_active_high(hi), .start, .busy, .tx_valid, .tx_ready,
    .tx_data, .rx_word, .char_irq, .spi_clk_out(sclk), .spi_tx_out(mosi),
    .spi_rx_in(miso), .slave_select_out(sel));
  spi_slave_model i_slave (.sclk, .mosi, .sel, .act_high(hi), .idx(cfg.cs_index),
    .pol(pol[cfg.cs_index]), .pha(pha[cfg.cs_index]), .len_m1(cfg.len_m1), .reply,
    .miso, .got_word(got));

  initial forever #50 sys_clk = ~sys_clk;

  task cmp(input string what, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, e, s);
    end
  endtask : cmp

  task final_report;
    if (errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // every finished character against the model
  // ----------------------------------------------------------------
  always @(negedge sys_clk) if (arst_n && rx_word.valid === 1'b1) begin
    nv++;
    ni += (char_irq === 1'b1);
    cmp("rx data", exp_q.pop_front(), rx_word.data);
    if (!cfg.loopback) cmp("slave word", tx_q.pop_front(), got);
    else void'(tx_q.pop_front());
  end

  // hang guard, well beyond the longest run
  initial begin
    repeat (90000) @(posedge sys_clk);
    errors++;
    final_report();
  end

  // ----------------------------------------------------------------
  // main sequence: twelve frames over all selects, modes and delays
  // ----------------------------------------------------------------
  initial begin
    spi_cfg_t c;
    logic [3:0] lp, lf, lh;
    logic [31:0] rp, w, mk;
    int chars, h, t1, t2, n;
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int f = 0; f < 12; f++) begin
      c = spi_cfg_t'(31'($random(seed)));
      c.half_div = 8'h02 + 8'(c.half_div[1:0]); // three clocks or more per half period
      c.len_m1 = (f == 0) ? 5'h1f : (f == 1) ? 5'h00 : c.len_m1;
      c.frame_m1 = (f == 0) ? 12'h00f : 12'(c.frame_m1[1:0]); // first frame fills the fifo
      c.cs_index = 2'(f);
      c.cs_delay = 2'(f >> 1);
      c.loopback = f[0];
      c.irq_enable = f[1];
      {lp, lf, lh} = 12'($random(seed));
      lp[c.cs_index] = f[2];
      lf[c.cs_index] = f[3] ^ f[1];
      rp = $random(seed);
      cfg <= c;
      pol <= lp;
      pha <= lf;
      hi <= lh;
      reply <= rp;
      repeat (3) @(posedge sys_clk);
      chars = c.frame_m1 + 1;
      h = c.half_div + 1;
      mk = 32'hffffffff >> (5'h1f - c.len_m1);
      for (int k = 0; k < chars; k++) begin
        w = $random(seed);
        tx_q.push_back(w & mk);
        exp_q.push_back((c.loopback ? w : rp) & mk);
        tx_data <= w;
        tx_valid <= 1'b1;
        @(negedge sys_clk);
        while (tx_ready !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
      end
      tx_valid <= 1'b0;
      if (f == 0) begin
        @(negedge sys_clk);
        cmp("fifo ready when full", 32'h0, 32'(tx_ready));
        @(posedge sys_clk);
      end
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
      nv = 0;
      ni = 0;
      n = 0;
      t1 = 0;
      t2 = 0;
      // watch select and the first two clock edges until the frame ends
      do begin
        @(negedge sys_clk);
        n++;
        if (n == 1) cmp("select", {28'h0, (~lh) ^ (4'h1 << c.cs_index)}, {28'h0, sel});
        if (t1 == 0 && sclk !== lp[c.cs_index]) t1 = n;
        else if (t1 > 0 && t2 == 0 && sclk === lp[c.cs_index]) t2 = n;
      end while (busy === 1'b1);
      cmp("first edge", 32'(2 + (2 * c.cs_delay + 2) * h), 32'(t1));
      cmp("half period", 32'(h), 32'(t2 - t1));
      cmp("characters", 32'(chars), 32'(nv));
      cmp("interrupts", c.irq_enable ? 32'(chars) : 32'h0, 32'(ni));
      cmp("idle clock", 32'(lp[c.cs_index]), 32'(sclk));
      cmp("select released", {28'h0, ~lh}, {28'h0, sel});
    end
    final_report();
  end
endmodule : spi_master_four_select_test
